/* core/lcdc_top.sv */
// lcdc_top: lcd drive transfer control, command ports, blanking and panel supply switch
// assumes a cpu that grants a stolen instruction cycle once its instruction and
// pending timer or interrupt service are done, and a data memory readable in one cycle
`include "lcdc_regs.svh"

// Function
// R1 - transfers only while panel supply is applied
// R2 - multiplexed, base 0: 24 per 512
// R3 - static, base 0: 24 per 2048
// R4 - multiplexed, base 1: 24 per 256
// R5 - static, base 1: 24 per 1024
// R6 - wait for grant, then steal one cycle
// R7 - enable bit zero blanks, reset clears it
// R8 - blanking idles commons, segments keep running
// R9 - static blanking holds common at half
// R10 - enabled display shows stored area data
// R11 - first enable closes switch, blanking keeps it
// R12 - drive port codes: duty, blank, enable, invalid
// R13 - software changes area only while blanked; the code accepts area writes at any time and the bench writes it while enabled
// R14 - default area fetches addresses 80 to 97
// R15 - instruction cycle is four by four clocks
// R16 - reset initialises registers, opens supply switch
// R17 - hold opens switch, release restores state
// R18 - drive method field resets to zero
// R19 - base select picks divider, resets zero
// R20 - one word per transfer, in order, wrapping
module lcdc_top
	import lcdc_pkg::*;
(
	input  wire logic          clk_sys_i,     // basic clock, 10 MHz
	input  wire logic          resetn_i,      // async reset, active low
	input  wire lcdc_bus_req_t bus_i,         // register port request
	output logic         [7:0] rdata_o,       // read data, cycle after the read
	input  wire logic          hold_n_i,      // hold request pin, active low
	input  wire logic          cpu_grant_i,   // cpu free at this cycle boundary
	output logic               xfer_req_o,    // transfer request to the cpu
	output logic               steal_o,       // stolen instruction cycle in progress
	output lcdc_mem_req_t      mem_o,         // display area read
	input  wire logic    [3:0] mem_data_i,    // display word from data memory
	output lcdc_panel_t        panel_o,       // common and segment levels
	output logic               panel_power_o  // panel supply switch closed
);
	lcdc_top_st_t     s_r;
	lcdc_top_st_t     s_nxt;
	logic             ic_last;
	logic       [1:0] mcyc;
	logic [23:0][3:0] word;
	logic             hold;
	logic             active;
	logic             new_req;
	logic             store_wr;
	logic      [12:0] period;
	logic      [12:0] sum;
	logic      [12:0] lim;
	logic       [1:0] com_last;
	logic             step;
	logic             is_static;
	logic             on_bit;
	logic             restart;

	lcdc_icycle u_icycle
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.mcyc_o    (mcyc),
		.last_o    (ic_last)
	);

	lcdc_seg_store u_store
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_i      (store_wr),
		.idx_i     (s_r.widx),
		.data_i    (mem_data_i),
		.word_o    (word)
	);

	always_comb
	begin
		s_nxt     = s_r;
		new_req   = 1'b0;
		step      = 1'b0;
		on_bit    = 1'b0;
		sum       = 13'h0000;
		hold      = ~s_r.hsync[1];
		active    = s_r.pwr_sw & ~hold;                    // [R1] [R17]
		is_static = (s_r.duty == LCDC_DUTY_STATIC);
		store_wr  = (s_r.xst == LCDC_X_STEAL) && ic_last;
		restart   = bus_i.wr && (bus_i.addr == `LCDC_OFS_AREA
			|| bus_i.addr == `LCDC_OFS_DRIVE);
		s_nxt.hsync = {s_r.hsync[0], hold_n_i};
		s_nxt.rdata = 8'h00;

		// register port
		if (bus_i.wr)
		begin
			case (bus_i.addr)
				`LCDC_OFS_AREA:
				begin
					s_nxt.area = bus_i.wdata[3:0];
					s_nxt.acc  = 12'h000;
				end
				`LCDC_OFS_DRIVE:
				begin
					s_nxt.acc = 12'h000;
					case (bus_i.wdata[`LCDC_OP_MSB:`LCDC_OP_LSB])        // [R12]
						`LCDC_OP_DUTY:   s_nxt.duty = lcdc_duty_t'(bus_i.wdata[1:0]); // [R18]
						`LCDC_OP_BLANK:  s_nxt.den = 1'b0;                // [R7]
						`LCDC_OP_ENABLE:
						begin
							s_nxt.den    = 1'b1;                         // [R10]
							s_nxt.pwr_sw = 1'b1;                         // [R11]
						end
						default:         s_nxt.bad_cmd = 1'b1;            // [R12]
					endcase
				end
				default:
				begin
				end
			endcase
		end
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				`LCDC_OFS_AREA:   s_nxt.rdata = {4'h0, s_r.area};
				`LCDC_OFS_DRIVE:  s_nxt.rdata = {4'h0, s_r.den, 1'b0, s_r.duty};
				`LCDC_OFS_STATUS:
				begin
					s_nxt.rdata   = {s_r.widx, s_r.bad_cmd, s_r.xst == LCDC_X_WAIT,
						s_r.pwr_out};
					if (!bus_i.wr)
						s_nxt.bad_cmd = 1'b0;       // a flagging write wins over the clear
				end
				default:          s_nxt.rdata = 8'h00;
			endcase
		end

		// transfer rate: 24 requests spread over each period
		case ({is_static, s_r.area[`LCDC_SLF_BIT]})
			2'b00:   period = `LCDC_PER_MUX_SLF0;   // [R2]
			2'b10:   period = `LCDC_PER_STAT_SLF0;  // [R3]
			2'b01:   period = `LCDC_PER_MUX_SLF1;   // [R4]
			default: period = `LCDC_PER_STAT_SLF1;  // [R5]
		endcase
		// a restarting write must not be undone by a step in the same cycle
		if (active && ic_last && !restart)             // [R1]
		begin
			sum = {1'b0, s_r.acc} + `LCDC_XFER_STEP;
			if (sum >= period)
			begin
				sum     = sum - period;
				new_req = 1'b1;
			end
			s_nxt.acc = sum[11:0];
		end

		// cycle stealing
		case (s_r.xst)
			LCDC_X_IDLE:
				if (new_req)
					s_nxt.xst = LCDC_X_WAIT;
			LCDC_X_WAIT:
				if (ic_last && cpu_grant_i && active)    // [R6]
				begin
					s_nxt.xst   = LCDC_X_STEAL;
					s_nxt.maddr = {s_r.area[`LCDC_AREA_MSB:`LCDC_AREA_LSB], s_r.widx}; // [R14]
				end
			LCDC_X_STEAL:
				if (ic_last)                              // [R6]
				begin
					s_nxt.xst  = new_req ? LCDC_X_WAIT : LCDC_X_IDLE;
					s_nxt.widx = (s_r.widx == `LCDC_WORD_LAST) ? 5'h00 : s_r.widx + 5'h01; // [R20]
				end
			default:
				s_nxt.xst = LCDC_X_IDLE;
		endcase

		// frame timing from the selected divider output
		lim = s_r.area[`LCDC_SLF_BIT] ? `LCDC_PHASE_SLF1 : `LCDC_PHASE_SLF0; // [R19]
		case (s_r.duty)
			LCDC_DUTY_4: com_last = 2'h3;
			LCDC_DUTY_3: com_last = 2'h2;
			LCDC_DUTY_2: com_last = 2'h1;
			default:     com_last = 2'h0;
		endcase
		if (active)                                    // [R17]
		begin
			if (s_r.div == lim - 13'h0001)
			begin
				s_nxt.div = 13'h0000;
				if (is_static)
				begin
					s_nxt.sdiv = s_r.sdiv + 2'h1;
					step       = (s_r.sdiv == `LCDC_STATIC_SUB);
				end
				else
					step = 1'b1;
			end
			else
				s_nxt.div = s_r.div + 13'h0001;
		end
		if (step)
		begin
			s_nxt.pol = ~s_r.pol;
			if (s_r.pol)
				s_nxt.comi = (s_r.comi >= com_last) ? 2'h0 : s_r.comi + 2'h1;
		end

		// drive levels
		s_nxt.pwr_out = active;                        // [R16] [R17]
		for (int j = 0; j < 4; j++)
		begin
			if (!active)
				s_nxt.panel.common_electrode_outputs[j] = LCDC_LVL_VDD;
			else if (is_static)
				s_nxt.panel.common_electrode_outputs[j] = !s_r.den ? LCDC_LVL_HALF :           // [R9]
					(s_r.pol ? LCDC_LVL_VDD : LCDC_LVL_VLC);
			else if (s_r.den && (j[1:0] == s_r.comi))
				s_nxt.panel.common_electrode_outputs[j] = s_r.pol ? LCDC_LVL_VDD : LCDC_LVL_VLC;
			else if (s_r.duty == LCDC_DUTY_2)
				s_nxt.panel.common_electrode_outputs[j] = LCDC_LVL_HALF;                      // [R8]
			else
				s_nxt.panel.common_electrode_outputs[j] = s_r.pol ? LCDC_LVL_2_3 : LCDC_LVL_1_3; // [R7] [R8]
		end
		for (int i = 0; i < 24; i++)
		begin
			on_bit = word[i][is_static ? 2'h0 : s_r.comi];              // [R10]
			if (!active)
				s_nxt.panel.seg[i] = LCDC_LVL_VDD;
			else if (on_bit)
				s_nxt.panel.seg[i] = s_r.pol ? LCDC_LVL_VLC : LCDC_LVL_VDD;
			else if (is_static)
				s_nxt.panel.seg[i] = s_r.pol ? LCDC_LVL_VDD : LCDC_LVL_VLC;
			else if (s_r.duty == LCDC_DUTY_2)
				s_nxt.panel.seg[i] = LCDC_LVL_HALF;
			else
				s_nxt.panel.seg[i] = s_r.pol ? LCDC_LVL_1_3 : LCDC_LVL_2_3;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_r       <= '0;                // [R16]
			s_r.hsync <= 2'b11;
			s_r.area  <= `LCDC_AREA_RST;    // [R19]
			s_r.den   <= `LCDC_DEN_RST;     // [R7]
			s_r.duty  <= LCDC_DUTY_4;       // [R18]
		end
		else
			s_r <= s_nxt;
	end

	assign rdata_o       = s_r.rdata;
	// state codes are one-hot apart from idle, so each flag is a plain state bit
	assign xfer_req_o    = s_r.xst[0];
	assign steal_o       = s_r.xst[1];
	assign mem_o.addr    = s_r.maddr;
	assign mem_o.rd      = s_r.xst[1];
	assign panel_o       = s_r.panel;
	assign panel_power_o = s_r.pwr_out;

	// checking helpers: instruction cycles between requests with a steady mode
	logic [11:0] gap_cnt_r;
	logic        gap_ok_r;
	logic [3:0]  ic_pos_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			gap_cnt_r <= 12'h000;
			gap_ok_r  <= 1'b0;
			ic_pos_r  <= 4'h0;
		end
		else
		begin
			ic_pos_r <= ic_pos_r + 4'h1;
			if (bus_i.wr || !active)
				gap_ok_r <= 1'b0;
			else if (new_req)
				gap_ok_r <= 1'b1;
			if (new_req)
				gap_cnt_r <= 12'h000;
			else if (active && ic_last)
				gap_cnt_r <= gap_cnt_r + 12'h001;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	no_unpowered_xfer_a: assert property (steal_o |-> s_r.pwr_sw) // [R1]
		else $error("transfer while panel supply off");
	rate_mux_slow_a: assert property ((new_req && gap_ok_r && !bus_i.wr && !is_static // [R2]
		&& !s_r.area[0]) |-> (gap_cnt_r >= 12'd20 && gap_cnt_r <= 12'd21))
		else $error("multiplexed slow transfer spacing wrong");
	rate_static_slow_a: assert property ((new_req && gap_ok_r && !bus_i.wr && is_static // [R3]
		&& !s_r.area[0]) |-> (gap_cnt_r >= 12'd84 && gap_cnt_r <= 12'd85))
		else $error("static slow transfer spacing wrong");
	rate_mux_fast_a: assert property ((new_req && gap_ok_r && !bus_i.wr && !is_static // [R4]
		&& s_r.area[0]) |-> (gap_cnt_r >= 12'd9 && gap_cnt_r <= 12'd10))
		else $error("multiplexed fast transfer spacing wrong");
	rate_static_fast_a: assert property ((new_req && gap_ok_r && !bus_i.wr && is_static // [R5]
		&& s_r.area[0]) |-> (gap_cnt_r >= 12'd41 && gap_cnt_r <= 12'd42))
		else $error("static fast transfer spacing wrong");
	steal_one_cycle_a: assert property ($rose(steal_o) |-> ic_pos_r == 4'h0 ##15 steal_o // [R6]
		##1 (!steal_o || $past(xfer_req_o) == 1'b0))
		else $error("stolen cycle not one instruction cycle");
	blank_com_idle_a: assert property ((active && !s_r.den && !is_static // [R8]
		&& s_r.duty != LCDC_DUTY_2) |=> (panel_o.common_electrode_outputs[0] == LCDC_LVL_2_3
		|| panel_o.common_electrode_outputs[0] == LCDC_LVL_1_3))
		else $error("blanked common not at non-lighting level");
	static_half_a: assert property ((active && !s_r.den && is_static) |=> // [R9]
		panel_o.common_electrode_outputs[0] == LCDC_LVL_HALF)
		else $error("static blank common not at half level");
	switch_kept_a: assert property (!$fell(s_r.pwr_sw)) // [R11]
		else $error("panel supply switch reopened");
	bad_code_a: assert property ((bus_i.wr && bus_i.addr == `LCDC_OFS_DRIVE // [R12]
		&& bus_i.wdata[3:2] == `LCDC_OP_BAD) |=> s_r.bad_cmd)
		else $error("invalid drive command not flagged");
	first_word_addr_a: assert property ($rose(steal_o) && s_r.area == `LCDC_AREA_RST // [R14]
		|-> mem_o.addr >= 8'h80 && mem_o.addr <= 8'h97)
		else $error("default area address out of range");
	icycle_len_a: assert property (ic_last |-> ##16 ic_last) // [R15]
		else $error("instruction cycle not sixteen clocks");
	hold_dark_a: assert property (hold |=> !panel_power_o) // [R17]
		else $error("panel supply not cut in hold");
	word_wrap_a: assert property ((store_wr && s_r.widx == `LCDC_WORD_LAST) |=> // [R20]
		s_r.widx == 5'h00)
		else $error("word index does not wrap");

	steal_seen_c: cover property ($fell(steal_o));
	blank_seen_c: cover property (active && $fell(s_r.den));
	hold_seen_c:  cover property ($rose(hold) ##[1:8] !panel_power_o);
	wrap_seen_c:  cover property (store_wr && s_r.widx == `LCDC_WORD_LAST);

endmodule // lcdc_top

/* core/lcdc_regs.svh */
// lcdc_regs.svh: offsets, field positions, reset values and timing counts of the lcd drive block
// assumes an 8-bit register port with a 2-bit word address
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH

`define LCDC_OFS_AREA      2'h0
`define LCDC_OFS_DRIVE     2'h1
`define LCDC_OFS_STATUS    2'h2

`define LCDC_SLF_BIT       0
`define LCDC_AREA_MSB      3
`define LCDC_AREA_LSB      1
`define LCDC_OP_MSB        3
`define LCDC_OP_LSB        2
`define LCDC_OP_DUTY       2'h0
`define LCDC_OP_BLANK      2'h1
`define LCDC_OP_BAD        2'h2
`define LCDC_OP_ENABLE     2'h3

`define LCDC_AREA_RST      4'h8
`define LCDC_DEN_RST       1'b0

`define LCDC_IC_LAST       4'hF
`define LCDC_WORD_LAST     5'h17
`define LCDC_XFER_STEP     13'h0018
`define LCDC_PER_MUX_SLF0  13'h0200
`define LCDC_PER_STAT_SLF0 13'h0800
`define LCDC_PER_MUX_SLF1  13'h0100
`define LCDC_PER_STAT_SLF1 13'h0400
`define LCDC_PHASE_SLF0    13'h1000
`define LCDC_PHASE_SLF1    13'h0800
`define LCDC_STATIC_SUB    2'h3

`endif

/* core/lcdc_pkg.sv */
// lcdc_pkg: types shared by the lcd drive block
// assumes nothing beyond a SystemVerilog compiler
package lcdc_pkg;

	typedef enum logic [2:0]
	{
		LCDC_LVL_VDD  = 3'h0,
		LCDC_LVL_2_3  = 3'h1,
		LCDC_LVL_HALF = 3'h2,
		LCDC_LVL_1_3  = 3'h3,
		LCDC_LVL_VLC  = 3'h4
	} lcdc_lvl_t;

	typedef enum logic [1:0]
	{
		LCDC_DUTY_4      = 2'h0,
		LCDC_DUTY_3      = 2'h1,
		LCDC_DUTY_2      = 2'h2,
		LCDC_DUTY_STATIC = 2'h3
	} lcdc_duty_t;

	typedef enum logic [1:0]
	{
		LCDC_X_IDLE  = 2'b00,
		LCDC_X_WAIT  = 2'b01,
		LCDC_X_STEAL = 2'b10
	} lcdc_xfer_st_t;

	typedef struct packed
	{
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} lcdc_bus_req_t;

	typedef struct packed
	{
		logic [7:0] addr;
		logic       rd;
	} lcdc_mem_req_t;

	typedef struct packed
	{
		lcdc_lvl_t [3:0]  common_electrode_outputs;
		lcdc_lvl_t [23:0] seg;
	} lcdc_panel_t;

	typedef struct packed
	{
		logic [3:0] cnt;
	} lcdc_ic_st_t;

	typedef struct packed
	{
		logic [23:0][3:0] word;
	} lcdc_store_st_t;

	typedef struct packed
	{
		logic [1:0]    hsync;
		logic [3:0]    area;
		lcdc_duty_t    duty;
		logic          den;
		logic          pwr_sw;
		logic          bad_cmd;
		logic [11:0]   acc;
		lcdc_xfer_st_t xst;
		logic [4:0]    widx;
		logic [7:0]    maddr;
		logic [12:0]   div;
		logic [1:0]    sdiv;
		logic [1:0]    comi;
		logic          pol;
		logic [7:0]    rdata;
		logic          pwr_out;
		lcdc_panel_t   panel;
	} lcdc_top_st_t;

endpackage

/* core/lcdc_icycle.sv */
// lcdc_icycle: instruction cycle timing, sixteen basic clocks in four machine cycles
// assumes the basic clock as clk_sys_i and an asynchronous active-low reset
`include "lcdc_regs.svh"

module lcdc_icycle
	import lcdc_pkg::*;
(
	input  wire logic       clk_sys_i, // basic clock
	input  wire logic       resetn_i,  // async reset, active low
	output logic      [1:0] mcyc_o,    // current machine cycle
	output logic            last_o     // last basic clock of the instruction cycle
);
	lcdc_ic_st_t s_r;
	lcdc_ic_st_t s_nxt;

	always_comb
	begin
		s_nxt     = s_r;
		s_nxt.cnt = s_r.cnt + 4'h1; // [R15]
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign mcyc_o = s_r.cnt[3:2];                // [R15]
	assign last_o = (s_r.cnt == `LCDC_IC_LAST);  // [R15]

endmodule // lcdc_icycle

/* core/lcdc_seg_store.sv */
// lcdc_seg_store: the 24 display words held by the segment drivers
// assumes one write per stolen instruction cycle from the same clock domain
module lcdc_seg_store
	import lcdc_pkg::*;
(
	input  wire logic             clk_sys_i, // basic clock
	input  wire logic             resetn_i,  // async reset, active low
	input  wire logic             wr_i,      // load one word
	input  wire logic       [4:0] idx_i,     // word index 0..23
	input  wire logic       [3:0] data_i,    // display word
	output logic     [23:0][3:0]  word_o     // all held words
);
	lcdc_store_st_t s_r;
	lcdc_store_st_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (wr_i)
			s_nxt.word[idx_i] = data_i; // [R20]
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign word_o = s_r.word;

endmodule // lcdc_seg_store

/* bench/lcdc_cpu_mem_model.sv */
// lcdc_cpu_mem_model: cpu grant and display memory on the far side of the lcd drive block
// assumes the block's clock and reset, and a random busy hint from the bench
module lcdc_cpu_mem_model
	import lcdc_pkg::*;
(
	input  wire logic          clk_sys_i,  // basic clock
	input  wire logic          resetn_i,   // async reset, active low
	input  wire logic          slow_i,     // cpu still busy this cycle
	input  wire logic          xfer_req_i, // transfer request
	input  wire lcdc_mem_req_t mem_i,      // display area read
	output logic               grant_o,    // cpu free for a stolen cycle
	output logic         [3:0] data_o      // display word
);
	timeunit 1ns;
	timeprecision 100ps;

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			grant_o <= 1'b0;
			data_o  <= 4'h5;
		end
		else
		begin
			grant_o <= xfer_req_i && !slow_i;
			// unread memory shows a toggling word, never a held one
			data_o <= mem_i.rd ? (mem_i.addr[3:0] ^ mem_i.addr[7:4]) : ~data_o;
		end
	end
endmodule // lcdc_cpu_mem_model

/* bench/lcd_drive_transfer_control_tb.sv */
// lcd_drive_transfer_control_tb: self-checking bench of lcdc_top
// assumes the cpu and memory partner model and a 10 MHz basic clock
module lcd_drive_transfer_control_tb
	import lcdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic          clk_sys_i = 1'b0;
	logic          resetn_i  = 1'b0;
	logic          hold_n_i  = 1'b1;
	logic          slow      = 1'b0;
	lcdc_bus_req_t bus       = '0;
	logic    [7:0] rdata;
	logic          grant;
	logic          xfer_req;
	logic          steal;
	lcdc_mem_req_t mem;
	logic    [3:0] mdata;
	lcdc_panel_t   panel;
	logic          pwr;
	logic   [31:0] rnd = 32'hB23FE031;
	logic          g1 = 1'b0;
	logic          st_q = 1'b0;
	logic    [3:0] area_m = 4'h8;
	int            mismatches = 0;
	int            samples_checked = 0;
	int            cycles = 0;
	int            steals = 0;
	int            slen = 0;
	int            widx_m = 0;

	lcdc_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
		.hold_n_i(hold_n_i), .cpu_grant_i(grant), .xfer_req_o(xfer_req), .steal_o(steal),
		.mem_o(mem), .mem_data_i(mdata), .panel_o(panel), .panel_power_o(pwr));

	lcdc_cpu_mem_model partner (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .slow_i(slow),
		.xfer_req_i(xfer_req), .mem_i(mem), .grant_o(grant), .data_o(mdata));

	always #50 clk_sys_i = ~clk_sys_i;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_cnt(input string what, input int exp, input int got);
		samples_checked++;
		if (got != exp)
		begin
			mismatches++;
			$display("unexpected %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge clk_sys_i);
		bus.wr <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk_sys_i);
		bus.rd <= 1'b0;
		@(negedge clk_sys_i);
		d = rdata;
		@(posedge clk_sys_i);
	endtask

	task automatic ics(input int n);
		repeat (n * 16) @(posedge clk_sys_i);
	endtask

	task automatic wait_lvl(input logic v, input int n);
		while (steal !== v && n > 0)
		begin
			@(posedge clk_sys_i);
			n--;
		end
	endtask

	// stat: static common must sit at half; else commons must avoid select levels
	task automatic scan(input logic stat, input int n, output int bad);
		bad = 0;
		repeat (n)
		begin
			@(negedge clk_sys_i);
			for (int i = 0; i < 4; i++)
				if (stat ? (i == 0 && panel.common_electrode_outputs[0] !== LCDC_LVL_HALF)
					: (panel.common_electrode_outputs[i] === LCDC_LVL_VDD || panel.common_electrode_outputs[i] === LCDC_LVL_VLC))
					bad++;
		end
		@(posedge clk_sys_i);
	endtask

	always @(posedge clk_sys_i)
	begin
		rnd <= lfsr(rnd);
		slow <= rnd[0] & rnd[1];
		cycles++;
		if (cycles == 99000)
		begin
			mismatches++;
			end_sim();
		end
	end

	// steal monitor: grant one sample back, fetch address, length, word order
	always @(negedge clk_sys_i)
	begin
		g1 <= grant;
		st_q <= steal;
		if (!resetn_i)
		begin
			widx_m = 0;
			slen = 0;
			st_q <= 1'b0;
		end
		else
		begin
			if (steal === 1'b1)
				slen++;
			if (steal === 1'b1 && !st_q)
			begin
				steals++;
				chk("grant before steal", 8'h01, {7'h0, g1});
				chk("fetch address", {area_m[3:1], widx_m[4:0]}, mem.addr);
				chk("fetch strobe", 8'h01, {7'h0, mem.rd});
			end
			if (steal === 1'b0 && st_q)
			begin
				chk_cnt("steal length", 16, slen);
				slen = 0;
				widx_m = (widx_m == 23) ? 0 : widx_m + 1;
			end
		end
	end

	initial
	begin
		int bad;
		int s0;
		int k;
		logic [7:0] d;
		logic [7:0] rate [4][2];
		int per [4];
		rate = '{'{8'h00, 8'h08}, '{8'h03, 8'h08}, '{8'h00, 8'h09}, '{8'h03, 8'h09}};
		per = '{512, 2048, 256, 1024};
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(2'h0, d);
		chk("area reg", 8'h08, d);
		rd(2'h1, d);
		chk("drive reg", 8'h00, d);
		rd(2'h3, d);
		chk("unmapped read", 8'h00, d);
		chk("supply at reset", 8'h00, {7'h0, pwr});
		ics(100);
		chk_cnt("steals before enable", 0, steals);
		$display("test reset done");
		for (int c = 0; c < 4; c++)
		begin
			wr(2'h1, 8'(c));
			rd(2'h1, d);
			chk("duty field", 8'(c), d);
		end
		wr(2'h1, 8'h08);
		rd(2'h2, d);
		chk("invalid flag", 8'h04, d & 8'h04);
		rd(2'h2, d);
		chk("invalid cleared", 8'h00, d & 8'h04);
		rd(2'h1, d);
		chk("drive after invalid", 8'h03, d);
		$display("test commands done");
		wr(2'h1, 8'h0C);
		@(posedge clk_sys_i);
		chk("supply on enable", 8'h01, {7'h0, pwr});
		for (int m = 0; m < 4; m++)
		begin
			wr(2'h0, rate[m][1]);
			wr(2'h1, rate[m][0]);
			s0 = steals;
			ics(per[m]);
			// the last request of the period is still waiting for its stolen cycle
			k = 0;
			while ((xfer_req === 1'b1 || steal === 1'b1) && k < 400)
			begin
				@(posedge clk_sys_i);
				k++;
			end
			chk_cnt("transfers", 24, steals - s0);
		end
		$display("test rates done");
		wr(2'h1, 8'h04);
		wr(2'h0, 8'h0A);
		area_m = 4'hA;
		wr(2'h1, 8'h00);
		chk("supply after blank", 8'h01, {7'h0, pwr});
		rd(2'h1, d);
		chk("blanked drive reg", 8'h00, d);
		scan(1'b0, 5000, bad);
		chk_cnt("blank select levels", 0, bad);
		wr(2'h1, 8'h03);
		scan(1'b1, 5000, bad);
		chk_cnt("static blank common", 0, bad);
		wr(2'h1, 8'h00);
		wr(2'h1, 8'h0C);
		scan(1'b0, 5000, bad);
		chk_cnt("select levels shown", 1, (bad > 0) ? 1 : 0);
		wr(2'h1, 8'h03);
		bad = 0;
		// static: a lit segment runs opposite to the common; word i is its address nibbles xored
		repeat (64)
		begin
			@(negedge clk_sys_i);
			for (int i = 0; i < 24; i++)
				if ((panel.seg[i] !== panel.common_electrode_outputs[0]) != ((i >= 16) ^ i[0]))
					bad++;
		end
		@(posedge clk_sys_i);
		chk_cnt("static segment data", 0, bad);
		wr(2'h1, 8'h00);
		$display("test blanking done");
		wait_lvl(1'b1, 3000);
		wait_lvl(1'b0, 20);
		s0 = steals;
		hold_n_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		chk("supply in hold", 8'h00, {7'h0, pwr});
		ics(100);
		chk_cnt("steals in hold", s0, steals);
		hold_n_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		chk("supply after hold", 8'h01, {7'h0, pwr});
		rd(2'h1, d);
		chk("drive after hold", 8'h08, d);
		$display("test hold done");
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("supply in reset", 8'h00, {7'h0, pwr});
		resetn_i <= 1'b1;
		area_m = 4'h8;
		@(posedge clk_sys_i);
		rd(2'h0, d);
		chk("area after reset", 8'h08, d);
		s0 = steals;
		ics(50);
		chk_cnt("steals after reset", s0, steals);
		$display("test second reset done");
		end_sim();
	end
endmodule // lcd_drive_transfer_control_tb
